// ### rtl/gpmp_pkg.sv
// Purpose: shared constants and types of the gpio pin mux port
// Assumes: apb byte address is the register index times four
// Notes: all registers are 16 bits wide in the low half of the word
package gpmp_pkg;
  // register indices
  localparam logic [15:0] IDX_CTRL = 16'hC006;
  localparam logic [15:0] IDX_OUT_LO = 16'hC01E;
  localparam logic [15:0] IDX_IN_LO = 16'hC020;
  localparam logic [15:0] IDX_DIR_LO = 16'hC022;
  localparam logic [15:0] IDX_OUT_HI = 16'hC024;
  localparam logic [15:0] IDX_IN_HI = 16'hC026;
  localparam logic [15:0] IDX_DIR_HI = 16'hC028;
  localparam logic [15:0] IDX_INT_STAT = 16'hC02A;
  localparam logic [15:0] IDX_INT_MASK = 16'hC02C;
  localparam int PADDR_W = 18;
  // control register field positions
  localparam int WP_BIT = 15;
  localparam int TXEN_BIT = 14;
  localparam int ALTSS_BIT = 11;
  localparam int MODE_LSB = 8;
  localparam int HSS_GPIO_BIT = 7;
  localparam int HS_SERIAL_ON_EXT_BUS_BIT = 6;
  localparam int SPI_GPIO_BIT = 5;
  localparam int SPI_ON_EXT_BUS_BIT = 4;
  localparam int INT1_POL_BIT = 3;
  localparam int INT1_EN_BIT = 2;
  localparam int INT0_POL_BIT = 1;
  localparam int INT0_EN_BIT = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hCFFF;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [31:0] OUT_RST = 32'h0000_0000;
  localparam logic [31:0] DIR_RST = 32'h0000_0000;
  localparam logic [1:0] MASK_RST = 2'h0;
  // mode field codes
  localparam logic [2:0] MODE_IDE = 3'h4;
  localparam logic [2:0] MODE_HPI = 3'h5;
  localparam logic [2:0] MODE_SCAN = 3'h6;
  // pin positions
  localparam int PIN_TXEN = 30;
  localparam int PIN_SS_ALT = 15;
  localparam int PIN_EXT_INTERRUPT_ZERO = 24;
  localparam int PIN_EXT_INTERRUPT_ONE = 25;
  localparam int SPI_PIN_LSB = 8;
  localparam int SPI_SS_LANE = 1;
  localparam int HSS_PIN_LSB = 16;
  localparam int HSS_PIN_HI = 26;
  localparam int XD_SPI_LSB = 0;
  localparam int XD_HSS_LSB = 4;
  localparam int FUNC_LO_N = 16;
  localparam int FUNC_HI_LSB = 19;
  localparam int SYNC_W = 40;
  // state of the synchroniser
  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } gpmp_sync_state_t;
  // state of the top module
  typedef struct packed {
    logic [15:0] ctrl;
    logic [31:0] outData;
    logic [31:0] dirData;
    logic [1:0] intStat;
    logic [1:0] intMask;
    logic [1:0] irqPrev;
    logic [31:0] prdata;
    logic err;
    logic irq;
    logic [31:0] pinOut;
    logic [31:0] pinOe;
    logic [7:0] xdOut;
    logic [7:0] xdOe;
    logic [7:0] xdTaken;
    logic [3:0] spiIn;
    logic [3:0] hssIn;
    logic [21:0] funcIn;
  } gpmp_port_state_t;
endpackage

// ### rtl/gpmp_route_if.sv
// Purpose: routing settings passed from the register file to the mux
// Assumes: one clock, all signals come from flip-flops
// Notes: pinIn is the synchronised pin level
`timescale 1ns/1ps
`default_nettype none
interface gpmp_route_if;
  logic [15:0] ctrl;
  logic [31:0] outData;
  logic [31:0] dirData;
  logic [31:0] pinIn;
  modport regs (output ctrl, output outData, output dirData,
    output pinIn);
  modport mux (input ctrl, input outData, input dirData, input pinIn);
endinterface
`default_nettype wire

// ### rtl/gpmp_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to ref_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module gpmp_sync import gpmp_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // levels
  input wire logic [SYNC_W-1:0] rawIn,
  output logic [SYNC_W-1:0] syncOut
);
  gpmp_sync_state_t r_reg;
  gpmp_sync_state_t r_next;

  // shift through two stages
  always_comb begin
    r_next = r_reg;
    r_next.meta = rawIn;
    r_next.stable = r_reg.meta;
  end

  // register the state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign syncOut = r_reg.stable;
endmodule
`default_nettype wire

// ### rtl/gpmp_pin_mux.sv
// Purpose: steers peripheral lanes onto gpio pins or the memory bus
// Assumes: settings and pin levels come from flip-flops
// Notes: purely combinational, later groups win over earlier ones
`timescale 1ns/1ps
`default_nettype none
module gpmp_pin_mux import gpmp_pkg::*; (
  // settings
  gpmp_route_if.mux route,
  // peripheral lanes
  input wire logic txEnable,
  input wire logic [3:0] spiPadOut,
  input wire logic [3:0] spiPadOe,
  input wire logic [3:0] hssPadOut,
  input wire logic [3:0] hssPadOe,
  input wire logic [21:0] funcPadOut,
  input wire logic [21:0] funcPadOe,
  input wire logic [7:0] xdPin,
  // results
  output logic [31:0] pinOut,
  output logic [31:0] pinOe,
  output logic [7:0] xdOut,
  output logic [7:0] xdOe,
  output logic [7:0] xdTaken,
  output logic [3:0] spiIn,
  output logic [3:0] hssIn
);
  // priority: gpio registers, tx enable, hss, spi, mode field
  always_comb begin
    logic [2:0] mode;
    logic hssXd;
    logic spiXd;
    int pin;
    mode = route.ctrl[MODE_LSB+2 -: 3];
    hssXd = route.ctrl[HS_SERIAL_ON_EXT_BUS_BIT];
    spiXd = route.ctrl[SPI_ON_EXT_BUS_BIT];
    pin = 0;
    pinOut = route.outData; // [R15]
    pinOe = route.dirData; // [R18]
    xdOut = '0;
    xdOe = '0;
    xdTaken = '0;
    spiIn = '0;
    hssIn = '0;
    if (route.ctrl[TXEN_BIT]) begin
      pinOut[PIN_TXEN] = txEnable; // [R2]
      pinOe[PIN_TXEN] = 1'b1; // [R2]
    end
    for (int k = 0; k < 4; k++) begin
      pin = (k == 3) ? HSS_PIN_HI : HSS_PIN_LSB + k;
      if (hssXd) begin
        xdOut[XD_HSS_LSB+k] = hssPadOut[k]; // [R6]
        xdOe[XD_HSS_LSB+k] = hssPadOe[k];
        xdTaken[XD_HSS_LSB+k] = 1'b1;
        hssIn[k] = xdPin[XD_HSS_LSB+k];
      end else if (route.ctrl[HSS_GPIO_BIT]) begin
        pinOut[pin] = hssPadOut[k]; // [R5]
        pinOe[pin] = hssPadOe[k];
        hssIn[k] = route.pinIn[pin];
      end
      pin = SPI_PIN_LSB + k;
      if (k == SPI_SS_LANE && route.ctrl[ALTSS_BIT]) begin
        pin = PIN_SS_ALT; // [R3]
      end
      if (spiXd) begin
        xdOut[XD_SPI_LSB+k] = spiPadOut[k]; // [R8]
        xdOe[XD_SPI_LSB+k] = spiPadOe[k];
        xdTaken[XD_SPI_LSB+k] = 1'b1;
        spiIn[k] = xdPin[XD_SPI_LSB+k];
      end else if (route.ctrl[SPI_GPIO_BIT]) begin
        pinOut[pin] = spiPadOut[k]; // [R7]
        pinOe[pin] = spiPadOe[k];
        spiIn[k] = route.pinIn[pin];
      end
    end
    if (mode == MODE_IDE || mode == MODE_HPI || mode == MODE_SCAN) begin
      for (int k = 0; k < 22; k++) begin
        pin = (k < FUNC_LO_N) ? k : FUNC_HI_LSB + k - FUNC_LO_N;
        pinOut[pin] = funcPadOut[k]; // [R4]
        pinOe[pin] = funcPadOe[k];
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/gpmp_port.sv
// Purpose: gpio port with pin function mux and two edge interrupts
// Assumes: apb slave on ref_clk, zero wait states
// Notes: pins and memory bus lines pass a two-stage synchroniser
//
// What this block does
// [R1] write protect bit freezes the mode field until reset
// [R2] tx enable route bit drives port 1A tx enable onto gpio 30
// [R3] alternate slave select moves spi slave select from gpio 9 to 15
// [R4] mode field picks gpio, ide, host port or scan for its pins
// [R5] hss to gpio bit puts serial lanes on gpio 26 and 18 to 16
// [R6] hss to memory bus bit uses bus lines 15:12, winning over gpio
// [R7] spi to gpio bit puts spi lanes on gpio 11 to 8
// [R8] spi to memory bus uses lines 11:8, winning over both spi bits
// [R9] bit 3 picks rising or falling edge for interrupt line one
// [R10] bit 2 enables line one, gated by system gpio enable
// [R11] bit 1 picks rising or falling edge for interrupt line zero
// [R12] bit 0 enables line zero, gated by system gpio enable
// [R13] line one comes from gpio 25, line zero from gpio 24
// [R14] software writes zero to control bits 13 and 12
// [R15] output registers drive gpio 15:0 and gpio 31:16 bit for bit
// [R16] output register reads return last written value
// [R17] input registers return sampled pin levels, low and high half
// [R18] direction bit one makes the pin an output, reset all inputs
// [R19] pins synchronised before sampling, one request per edge
`timescale 1ns/1ps
`default_nettype none
module gpmp_port import gpmp_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // gpio pins
  input wire logic [31:0] gpioIn,
  output logic [31:0] gpioOut,
  output logic [31:0] gpioOe,
  // memory data bus lines 15:8
  input wire logic [7:0] xdIn,
  output logic [7:0] xdOut,
  output logic [7:0] xdOe,
  output logic [7:0] xdTaken,
  // usb port 1A transmitter enable
  input wire logic txEnableStatus,
  // spi lanes: sck, slave select, mosi, miso
  input wire logic [3:0] spiPadOut,
  input wire logic [3:0] spiPadOe,
  output logic [3:0] spiPadIn,
  // high speed serial lanes
  input wire logic [3:0] hssPadOut,
  input wire logic [3:0] hssPadOe,
  output logic [3:0] hssPadIn,
  // ide, host port or scan lanes
  input wire logic [21:0] funcPadOut,
  input wire logic [21:0] funcPadOe,
  output logic [21:0] funcPadIn,
  output logic modeIde,
  output logic modeHpi,
  output logic modeScan,
  // interrupt
  input wire logic sysGpioIntEnable,
  output logic gpioIrq
);
  gpmp_port_state_t r_reg;
  gpmp_port_state_t r_next;
  logic [SYNC_W-1:0] syncBus;
  logic [31:0] pinSync;
  logic [7:0] xdSync;
  logic [31:0] muxPinOut;
  logic [31:0] muxPinOe;
  logic [7:0] muxXdOut;
  logic [7:0] muxXdOe;
  logic [7:0] muxXdTaken;
  logic [3:0] muxSpiIn;
  logic [3:0] muxHssIn;

  gpmp_route_if route ();

  // pin and bus line synchroniser
  gpmp_sync u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .rawIn({xdIn, gpioIn}),
    .syncOut(syncBus)
  );

  assign pinSync = syncBus[31:0]; // [R19]
  assign xdSync = syncBus[39:32];

  // settings handed to the mux
  assign route.ctrl = r_reg.ctrl;
  assign route.outData = r_reg.outData;
  assign route.dirData = r_reg.dirData;
  assign route.pinIn = pinSync;

  // function steering
  gpmp_pin_mux u_mux (
    .route(route),
    .txEnable(txEnableStatus),
    .spiPadOut(spiPadOut),
    .spiPadOe(spiPadOe),
    .hssPadOut(hssPadOut),
    .hssPadOe(hssPadOe),
    .funcPadOut(funcPadOut),
    .funcPadOe(funcPadOe),
    .xdPin(xdSync),
    .pinOut(muxPinOut),
    .pinOe(muxPinOe),
    .xdOut(muxXdOut),
    .xdOe(muxXdOe),
    .xdTaken(muxXdTaken),
    .spiIn(muxSpiIn),
    .hssIn(muxHssIn)
  );

  // merges byte lanes of a 16-bit register
  function automatic logic [15:0] laneMerge(
    input logic [15:0] old,
    input logic [15:0] wdata,
    input logic [1:0] strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // register file, edge detect and output staging
  always_comb begin
    logic setup;
    logic access;
    logic hit;
    logic [15:0] idx;
    logic [15:0] rd;
    logic [15:0] wval;
    logic [1:0] clr;
    logic [1:0] cur;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] pol;
    logic [1:0] en;
    logic [1:0] ev;
    r_next = r_reg;
    cur = 2'h0;
    rise = 2'h0;
    fall = 2'h0;
    pol = 2'h0;
    en = 2'h0;
    ev = 2'h0;
    setup = psel & ~penable;
    access = psel & penable;
    hit = 1'b1;
    idx = paddr[PADDR_W-1:2];
    rd = 16'h0000;
    wval = 16'h0000;
    clr = 2'h0;

    // read decode in the setup cycle, data held for the access cycle
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (idx == IDX_CTRL) begin
      rd = r_reg.ctrl & CTRL_WMASK;
    end else if (idx == IDX_OUT_LO) begin
      rd = r_reg.outData[15:0]; // [R16]
    end else if (idx == IDX_OUT_HI) begin
      rd = r_reg.outData[31:16]; // [R16]
    end else if (idx == IDX_IN_LO) begin
      rd = pinSync[15:0]; // [R17]
    end else if (idx == IDX_IN_HI) begin
      rd = pinSync[31:16]; // [R17]
    end else if (idx == IDX_DIR_LO) begin
      rd = r_reg.dirData[15:0];
    end else if (idx == IDX_DIR_HI) begin
      rd = r_reg.dirData[31:16];
    end else if (idx == IDX_INT_STAT) begin
      rd = {14'h0000, r_reg.intStat};
    end else if (idx == IDX_INT_MASK) begin
      rd = {14'h0000, r_reg.intMask};
    end else begin
      hit = 1'b0;
    end
    if (setup) begin
      r_next.prdata = {16'h0000, rd};
      r_next.err = ~hit;
    end

    // writes take effect at the end of the access cycle
    if (access && pwrite && !r_reg.err) begin
      if (idx == IDX_CTRL) begin
        wval = laneMerge(r_reg.ctrl, pwdata[15:0], pstrb[1:0]);
        wval = wval & CTRL_WMASK; // [R14]
        if (r_reg.ctrl[WP_BIT]) begin
          wval[MODE_LSB+2 -: 3] = r_reg.ctrl[MODE_LSB+2 -: 3]; // [R1]
          wval[WP_BIT] = 1'b1; // [R1]
        end
        r_next.ctrl = wval;
      end else if (idx == IDX_OUT_LO) begin
        r_next.outData[15:0] =
          laneMerge(r_reg.outData[15:0], pwdata[15:0], pstrb[1:0]);
      end else if (idx == IDX_OUT_HI) begin
        r_next.outData[31:16] =
          laneMerge(r_reg.outData[31:16], pwdata[15:0], pstrb[1:0]);
      end else if (idx == IDX_DIR_LO) begin
        r_next.dirData[15:0] =
          laneMerge(r_reg.dirData[15:0], pwdata[15:0], pstrb[1:0]);
      end else if (idx == IDX_DIR_HI) begin
        r_next.dirData[31:16] =
          laneMerge(r_reg.dirData[31:16], pwdata[15:0], pstrb[1:0]);
      end else if (idx == IDX_INT_STAT) begin
        clr = pwdata[1:0] & {2{pstrb[0]}};
      end else if (idx == IDX_INT_MASK) begin
        if (pstrb[0]) begin
          r_next.intMask = pwdata[1:0];
        end
      end
    end

    // edge detect on the synchronised interrupt pins
    cur = {pinSync[PIN_EXT_INTERRUPT_ONE], pinSync[PIN_EXT_INTERRUPT_ZERO]}; // [R13]
    rise = cur & ~r_reg.irqPrev; // [R19]
    fall = ~cur & r_reg.irqPrev; // [R19]
    pol = {r_reg.ctrl[INT1_POL_BIT], r_reg.ctrl[INT0_POL_BIT]};
    en = {r_reg.ctrl[INT1_EN_BIT], r_reg.ctrl[INT0_EN_BIT]};
    ev[1] = en[1] & (pol[1] ? rise[1] : fall[1]); // [R9] [R10]
    ev[0] = en[0] & (pol[0] ? rise[0] : fall[0]); // [R11] [R12]
    r_next.irqPrev = cur;

    // sticky status, a new edge wins over a clear
    r_next.intStat = (r_reg.intStat & ~clr) | ev;

    // interrupt only with the system gpio enable
    r_next.irq = (|(r_reg.intStat & r_reg.intMask)) & sysGpioIntEnable; // [R10] [R12]

    // stage pin, bus and lane values into flip-flops
    r_next.pinOut = muxPinOut; // [R15]
    r_next.pinOe = muxPinOe; // [R18]
    r_next.xdOut = muxXdOut;
    r_next.xdOe = muxXdOe;
    r_next.xdTaken = muxXdTaken;
    r_next.spiIn = muxSpiIn;
    r_next.hssIn = muxHssIn;
    r_next.funcIn = {pinSync[24:19], pinSync[15:0]};
  end

  // register the state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.ctrl <= CTRL_RST;
      r_reg.outData <= OUT_RST;
      r_reg.dirData <= DIR_RST; // [R18]
      r_reg.intMask <= MASK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // apb answer, zero wait states
  assign prdata = r_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = r_reg.err & psel & penable;

  // pin, bus and lane outputs
  assign gpioOut = r_reg.pinOut;
  assign gpioOe = r_reg.pinOe;
  assign xdOut = r_reg.xdOut;
  assign xdOe = r_reg.xdOe;
  assign xdTaken = r_reg.xdTaken;
  assign spiPadIn = r_reg.spiIn;
  assign hssPadIn = r_reg.hssIn;
  assign funcPadIn = r_reg.funcIn;

  // mode indications for the routed peripherals
  assign modeIde = r_reg.ctrl[MODE_LSB+2 -: 3] == MODE_IDE; // [R4]
  assign modeHpi = r_reg.ctrl[MODE_LSB+2 -: 3] == MODE_HPI; // [R4]
  assign modeScan = r_reg.ctrl[MODE_LSB+2 -: 3] == MODE_SCAN; // [R4]

  // interrupt output
  assign gpioIrq = r_reg.irq;
endmodule
`default_nettype wire

// ### testbench/gpmp_port_props.sv
// Purpose: checker for the gpio pin mux port
// Assumes: sees only the top module ports
// Notes: bound into every gpmp_port instance
`timescale 1ns/1ps
`default_nettype none
module gpmp_port_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // pins and lanes
  input wire logic [31:0] gpioIn,
  input wire logic [31:0] gpioOe,
  input wire logic [7:0] xdOe,
  input wire logic [7:0] xdTaken,
  input wire logic [21:0] funcPadIn,
  input wire logic modeIde,
  input wire logic modeHpi,
  input wire logic modeScan,
  // interrupt
  input wire logic sysGpioIntEnable,
  input wire logic gpioIrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // apb, reset, mode, bus line and pin sampling relations
  property p_rd_hi;
    psel && penable |-> prdata[31:16] == 16'h0000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_reset_oe;
    $fell(sys_rst) |-> gpioOe == 32'h0000_0000 && !gpioIrq;
  endproperty
  a_reset_oe: assert property (p_reset_oe) else $error("pins driven after reset");
  property p_mode_one;
    $onehot0({modeIde, modeHpi, modeScan});
  endproperty
  a_mode_one: assert property (p_mode_one) else $error("two modes at once");
  property p_xd_taken;
    (xdOe & ~xdTaken) == 8'h00;
  endproperty
  a_xd_taken: assert property (p_xd_taken) else $error("bus line driven untaken");
  property p_func_sync;
    ($stable(gpioIn) && !$past(sys_rst)) [*5]
      |-> funcPadIn == {gpioIn[24:19], gpioIn[15:0]};
  endproperty
  a_func_sync: assert property (p_func_sync) else $error("pin level not sampled");
  // interrupt relations
  property p_irq_gate;
    gpioIrq |-> $past(sysGpioIntEnable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_irq_low;
    !sysGpioIntEnable [*2] |-> !gpioIrq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq while disabled");
  property p_irq_hold;
    gpioIrq && sysGpioIntEnable && !(psel && penable)
      && !$past(psel && penable) |=> gpioIrq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  // main scenarios
  c_err: cover property (psel && penable && pslverr);
  c_irq: cover property ($rose(gpioIrq));
  c_ide: cover property (modeIde);
endmodule
bind gpmp_port gpmp_port_props u_gpmp_port_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .prdata(prdata), .pslverr(pslverr),
  .gpioIn(gpioIn), .gpioOe(gpioOe), .xdOe(xdOe), .xdTaken(xdTaken),
  .funcPadIn(funcPadIn), .modeIde(modeIde), .modeHpi(modeHpi),
  .modeScan(modeScan), .sysGpioIntEnable(sysGpioIntEnable),
  .gpioIrq(gpioIrq));
`default_nettype wire

// ### testbench/gpmp_board.sv
// Purpose: board model on the gpio pins
// Assumes: undriven pins follow the board level
// Notes: driven pins read back the device level
`timescale 1ns/1ps
`default_nettype none
module gpmp_board (
  // pins
  input wire logic [31:0] gpioOut,
  input wire logic [31:0] gpioOe,
  input wire logic [31:0] boardLvl,
  output logic [31:0] gpioIn
);
  // wired level of each pin
  assign gpioIn = (gpioOut & gpioOe) | (boardLvl & ~gpioOe);
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Purpose: self-checking bench of the gpio pin mux port
// Assumes: zero-wait apb slave, board model on the pins
// Notes: byte address is the register index times four
`timescale 1ns/1ps
`default_nettype none
module tb import gpmp_pkg::*; ;
  // bench signals
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, gpioIn, gpioOut, gpioOe, board, rdv;
  logic [7:0] xdOut, xdOe, xdTaken;
  logic [3:0] spiOut, spiIn, hssOut, hssIn;
  logic [21:0] fOut, fIn;
  logic txEn, sysEn, mIde, mHpi, mScan, irq, errv;
  int bad_count = 0;
  int cmp_count = 0;
  // device and board
  gpmp_port u_gpmp_port (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpioIn(gpioIn), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .xdIn(8'h00), .xdOut(xdOut), .xdOe(xdOe),
    .xdTaken(xdTaken), .txEnableStatus(txEn), .spiPadOut(spiOut),
    .spiPadOe(4'hF), .spiPadIn(spiIn), .hssPadOut(hssOut),
    .hssPadOe(4'hF), .hssPadIn(hssIn), .funcPadOut(fOut),
    .funcPadOe(22'h3F_FFFF), .funcPadIn(fIn), .modeIde(mIde),
    .modeHpi(mHpi), .modeScan(mScan), .sysGpioIntEnable(sysEn),
    .gpioIrq(irq));
  gpmp_board u_gpmp_board (.gpioOut(gpioOut), .gpioOe(gpioOe),
    .boardLvl(board), .gpioIn(gpioIn));
  // free running clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // shared helpers
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic [15:0] idx, input logic w,
      input logic [15:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [15:0] idx, d);
    apb(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [15:0] idx, e, input string nm);
    apb(idx, 1'b0, 16'h0000);
    chk(nm, {16'h0000, e}, rdv);
  endtask
  task automatic setc(input logic [15:0] c);
    wr(IDX_CTRL, c);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic doReset();
    sys_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
  endtask
  // scenarios
  task automatic tReset();
    rd(IDX_CTRL, 16'h0000, "ctrl");
    rd(IDX_OUT_LO, 16'h0000, "outLo");
    rd(IDX_OUT_HI, 16'h0000, "outHi");
    chk("oeRst", 32'h0000_0000, gpioOe);
  endtask
  task automatic tOutputs();
    wr(IDX_DIR_LO, 16'hFFFF);
    wr(IDX_DIR_HI, 16'hFFFF);
    wr(IDX_OUT_LO, 16'hA5C3);
    wr(IDX_OUT_HI, 16'h3C5A);
    repeat (6) @(posedge ref_clk);
    chk("out", 32'h3C5A_A5C3, gpioOut);
    chk("oe", 32'hFFFF_FFFF, gpioOe);
    rd(IDX_IN_HI, 16'h3C5A, "inDrv");
    wr(IDX_DIR_LO, 16'h0000);
    rd(IDX_OUT_LO, 16'hA5C3, "outBack");
  endtask
  task automatic tInputs();
    wr(IDX_DIR_HI, 16'h0000);
    board <= 32'h1234_ABCD;
    repeat (6) @(posedge ref_clk);
    chk("oeIn", 32'h0000_0000, gpioOe);
    rd(IDX_IN_LO, 16'hABCD, "inLo");
    wr(IDX_IN_HI, 16'h0000);
    rd(IDX_IN_HI, 16'h1234, "inHi");
  endtask
  task automatic tModes();
    logic [2:0] m, e;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      e = {m == MODE_IDE, m == MODE_HPI, m == MODE_SCAN};
      setc({5'b00000, m, 8'h00});
      chk("mode", 32'(e), 32'({mIde, mHpi, mScan}));
      if (e != 3'h0) begin
        chk("func", 32'(fOut), 32'({gpioOut[24:19], gpioOut[15:0]}));
      end
    end
  endtask
  task automatic tRoutes();
    wr(IDX_OUT_HI, 16'hFFFF);
    setc(16'h4000);
    chk("txOe", 32'h1, 32'(gpioOe[30]));
    chk("txLo", 32'h0, 32'(gpioOut[30]));
    txEn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("txHi", 32'h1, 32'(gpioOut[30]));
    setc(16'h0020);
    chk("spi", 32'h9, 32'(gpioOut[11:8]));
    repeat (2) @(posedge ref_clk);
    chk("spiIn", 32'h9, 32'(spiIn));
    setc(16'h0820);
    chk("altSs", 32'h0, 32'(gpioOut[15]));
    setc(16'h0830);
    chk("spiXd", 32'hF9, 32'({xdTaken[3:0], xdOut[3:0]}));
    setc(16'h0080);
    chk("hss", 32'h6, 32'({gpioOut[26], gpioOut[18:16]}));
    repeat (2) @(posedge ref_clk);
    chk("hssIn", 32'h6, 32'(hssIn));
    setc(16'h00C0);
    chk("hssXd", 32'hF6, 32'({xdTaken[7:4], xdOut[7:4]}));
    chk("hssFree", 32'hF, 32'({gpioOut[26], gpioOut[18:16]}));
  endtask
  task automatic tIrq();
    sysEn <= 1'b1;
    wr(IDX_INT_MASK, 16'h0003);
    setc(16'h0007);
    board <= 32'h1334_ABCD;
    repeat (6) @(posedge ref_clk);
    chk("irq", 32'h1, 32'(irq));
    rd(IDX_INT_STAT, 16'h0001, "stat0");
    wr(IDX_INT_STAT, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk("clr", 32'h0, 32'(irq));
    board <= 32'h1134_ABCD;
    repeat (6) @(posedge ref_clk);
    rd(IDX_INT_STAT, 16'h0002, "stat1");
    wr(IDX_INT_MASK, 16'h0000);
    repeat (2) @(posedge ref_clk);
    chk("mask", 32'h0, 32'(irq));
    wr(IDX_INT_MASK, 16'h0003);
    sysEn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("gate", 32'h0, 32'(irq));
    wr(IDX_INT_STAT, 16'h0003);
    board <= 32'h1034_ABCD;
    repeat (6) @(posedge ref_clk);
    rd(IDX_INT_STAT, 16'h0000, "pol");
  endtask
  task automatic tUnmapped();
    apb(16'hC000, 1'b0, 16'h0000);
    chk("err", 32'h1, 32'(errv));
    chk("errData", 32'h0, rdv);
  endtask
  task automatic tProtect();
    wr(IDX_CTRL, 16'hCFFF);
    rd(IDX_CTRL, 16'hCFFF, "ctrlMask");
    wr(IDX_CTRL, 16'h0000);
    rd(IDX_CTRL, 16'h8700, "ctrlLock");
    doReset();
    rd(IDX_CTRL, 16'h0000, "ctrlRst");
  endtask
  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    results();
  end
  // main sequence
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0_0000;
    pwdata = 32'h0000_0000;
    board = 32'h0000_0000;
    txEn = 1'b0;
    sysEn = 1'b0;
    spiOut = 4'h9;
    hssOut = 4'h6;
    fOut = 22'h2A_5A5A;
    doReset();
    tReset();
    tOutputs();
    tInputs();
    tModes();
    tRoutes();
    tIrq();
    tUnmapped();
    tProtect();
    results();
  end
endmodule
`default_nettype wire
